// ==== sspi_pkg.sv ====
// package: constants for the clock-stop serial port block
package sspi_pkg;
	localparam int DIV_W = 8;
	localparam int WORD_W = 8;
	localparam int CNT_W = 6;
	localparam int CPU_DIV = 4;
	localparam logic [1:0] CPU_DIV_LAST = 2'h3;
	localparam logic [1:0] STOP_OFF = 2'h0;
	localparam logic [1:0] STOP_RISE_LAUNCH = 2'h2;
	localparam logic [1:0] STOP_FALL_LAUNCH = 2'h3;
	localparam logic [DIV_W-1:0] SLAVE_DIVIDER = 8'h01;
	localparam logic SRC_CPU = 1'b1;
	typedef enum logic [2:0] {SSPI_IDLE, SSPI_LEAD, SSPI_HIGH, SSPI_LOW, SSPI_TAIL} sspi_state_e;
endpackage : sspi_pkg

// ==== sspi_rate_gen.sv ====
// sample-rate generator: source select and programmable bit-clock divider
`timescale 1ns/10ps
module sspi_rate_gen #(
	parameter int DIV_W = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic rateGenSourceSelect,
	input wire logic extRateClock,
	input wire logic [DIV_W-1:0] clockDivider,
	output logic srcTick,
	output logic [DIV_W:0] highCount,
	output logic [DIV_W:0] lowCount
);
	import sspi_pkg::*;
	logic [1:0] cpuCount;
	logic [2:0] extSync;
	// external clock passes three flops; rising edge counted when second is high and third still low
	always_ff @(posedge mclk) begin
		if (rst) begin
			extSync <= 3'h0;
		end else begin
			extSync <= {extSync[1:0], extRateClock};
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			cpuCount <= 2'h0;
		end else begin
			cpuCount <= cpuCount + 2'h1;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			srcTick <= 1'b0;
		end else if (rateGenSourceSelect == SRC_CPU) begin
			srcTick <= (cpuCount == CPU_DIV_LAST);
		end else begin
			srcTick <= extSync[1] & ~extSync[2];
		end
	end
	// phase split, nonzero even divider gives the longer high phase
	always_ff @(posedge mclk) begin
		if (rst) begin
			highCount <= '0;
			lowCount <= '0;
		end else if (!clockDivider[0] && clockDivider != '0) begin
			highCount <= {1'b0, clockDivider >> 1} + 1'b1;
			lowCount <= {1'b0, clockDivider >> 1};
		end else begin
			highCount <= ({1'b0, clockDivider} + 1'b1) >> 1;
			lowCount <= ({1'b0, clockDivider} + 1'b1) >> 1;
		end
	end
endmodule : sspi_rate_gen

// ==== sspi_clock_stop.sv ====
// clock-stop SPI master/slave shifter with its sample-rate generator
// Summary of operation
// - bit clock period is (1 + clock_divider) source periods; a divider of zero gives two.
// - nonzero even divider: high is half plus one, low half; else both (div+1)/2.
// - source is CPU clock over four when select is 1, else external clock.
// - master with both sync polarities set drives slave-enable active low.
// - slave inverts active-low slave-enable inputs before internal use.
// - master: tx clock and tx sync are outputs, rx ones inputs.
// - slave: all four clock and sync directions are inputs.
// - slave mode requires CPU/4 source with divider of one.
// - master asserts slave-enable low before first rising edge, transfer starts there.
// - mode 10b launches data on rising edge, peer captures on falling.
// - mode 11b launches data on falling edge, peer captures on rising.
// - mode 10b enable leads by low phase, trails one full period.
// - mode 11b enable leads by full period, trails one low phase.
// - mode 10b master releases data output a low phase after last fall.
// - slave releases data output once slave-enable rises after last bit.
`timescale 1ns/10ps
module sspi_clock_stop #(
	parameter int DIV_W = sspi_pkg::DIV_W,
	parameter int WORD_W = sspi_pkg::WORD_W
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic masterMode,
	input wire logic [1:0] clockStopMode,
	input wire logic txClockPolarity,
	input wire logic txSyncPolarity,
	input wire logic rxSyncPolarity,
	input wire logic rateGenSourceSelect,
	input wire logic [DIV_W-1:0] clockDivider,
	input wire logic extRateClock,
	input wire logic txStart,
	input wire logic [WORD_W-1:0] txWord,
	output logic txBusy,
	output logic [WORD_W-1:0] rxWord,
	output logic rxValid,
	output logic configError,
	output logic txClockDirection,
	output logic rxClockDirection,
	output logic txSyncDirection,
	output logic rxSyncDirection,
	input wire logic txBitClockIn,
	output logic txBitClockOut,
	output logic txBitClockOe,
	input wire logic txFrameSyncIn,
	output logic txFrameSyncOut,
	output logic txFrameSyncOe,
	input wire logic rxFrameSyncIn,
	output logic serialDataOut,
	output logic serialDataOutOe,
	input wire logic serialDataIn
);
	import sspi_pkg::*;
	sspi_state_e state;
	logic srcTick;
	logic [DIV_W:0] highCount;
	logic [DIV_W:0] lowCount;
	logic [DIV_W:0] phaseCount;
	logic [CNT_W-1:0] bitCount;
	logic [WORD_W-1:0] shiftOut;
	logic [WORD_W-1:0] shiftIn;
	logic [2:0] sclkSync;
	logic [2:0] selTxSync;
	logic [2:0] selRxSync;
	logic [2:0] sdiSync;
	logic slaveSelect;
	logic slaveSelectPrev;
	logic sclkPrev;
	logic fallLaunch;
	logic phaseDone;
	logic lastBit;
	logic armed;
	logic frameEnd;
	assign fallLaunch = (clockStopMode == STOP_FALL_LAUNCH);
	assign phaseDone = srcTick && (phaseCount <= 1);
	assign lastBit = (bitCount == CNT_W'(WORD_W - 1));
	// mode 11b frame ends with the low phase after the last fall
	assign frameEnd = fallLaunch && state == SSPI_LOW && lastBit && phaseDone;

	sspi_rate_gen #(.DIV_W(DIV_W)) rateGen (
		.mclk(mclk),
		.rst(rst),
		.rateGenSourceSelect(rateGenSourceSelect),
		.extRateClock(extRateClock),
		.clockDivider(clockDivider),
		.srcTick(srcTick),
		.highCount(highCount),
		.lowCount(lowCount)
	);

	// pin inputs: three flops each, clock and enable act when stages two and three agree
	always_ff @(posedge mclk) begin
		if (rst) begin
			sclkSync <= 3'h0;
			selTxSync <= 3'h7;
			selRxSync <= 3'h7;
			sdiSync <= 3'h0;
		end else begin
			sclkSync <= {sclkSync[1:0], txBitClockIn};
			selTxSync <= {selTxSync[1:0], txFrameSyncIn};
			selRxSync <= {selRxSync[1:0], rxFrameSyncIn};
			sdiSync <= {sdiSync[1:0], serialDataIn};
		end
	end

	// active-low enable inverted, tx and rx pins both needed
	always_ff @(posedge mclk) begin
		if (rst) begin
			slaveSelect <= 1'b0;
			sclkPrev <= 1'b0;
			slaveSelectPrev <= 1'b0;
		end else begin
			if (selTxSync[1] == selTxSync[2] && selRxSync[1] == selRxSync[2]) begin
				slaveSelect <= ~selTxSync[2] & ~selRxSync[2];
			end
			if (sclkSync[1] == sclkSync[2]) begin
				sclkPrev <= sclkSync[2];
			end
			slaveSelectPrev <= slaveSelect;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			txClockDirection <= 1'b0;
			txSyncDirection <= 1'b0;
			rxClockDirection <= 1'b0;
			rxSyncDirection <= 1'b0;
			configError <= 1'b0;
		end else begin
			txClockDirection <= masterMode;
			txSyncDirection <= masterMode;
			rxClockDirection <= 1'b0;
			rxSyncDirection <= 1'b0;
			// slave needs CPU/4 source, divider one
			configError <= (clockStopMode == STOP_OFF) || !txSyncPolarity
				|| !rxSyncPolarity || txClockPolarity
				|| (!masterMode && (rateGenSourceSelect != SRC_CPU
				|| clockDivider != SLAVE_DIVIDER));
		end
	end

	// master sequencer; period is high plus low phases
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= SSPI_IDLE;
			phaseCount <= '0;
			bitCount <= '0;
			armed <= 1'b0;
		end else if (!masterMode) begin
			state <= SSPI_IDLE;
			armed <= 1'b0;
		end else begin
			if (srcTick && phaseCount != '0) begin
				phaseCount <= phaseCount - 1'b1;
			end
			unique case (state)
				SSPI_IDLE: begin
					if (txStart && !configError) begin
						armed <= 1'b1;
					end
					// lead starts on a tick so it is whole
					if (armed && srcTick) begin
						armed <= 1'b0;
						state <= SSPI_LEAD;
						bitCount <= '0;
						phaseCount <= fallLaunch ? highCount + lowCount : lowCount;
					end
				end
				SSPI_LEAD: begin
					if (phaseDone) begin
						state <= SSPI_HIGH;
						phaseCount <= highCount;
					end
				end
				SSPI_HIGH: begin
					if (phaseDone) begin
						state <= SSPI_LOW;
						phaseCount <= lowCount;
					end
				end
				SSPI_LOW: begin
					if (phaseDone) begin
						if (lastBit) begin
							// trail is this low phase, plus a high in 10b
							state <= fallLaunch ? SSPI_IDLE : SSPI_TAIL;
							phaseCount <= highCount;
						end else begin
							state <= SSPI_HIGH;
							phaseCount <= highCount;
							bitCount <= bitCount + 1'b1;
						end
					end
				end
				SSPI_TAIL: begin
					if (phaseDone) begin
						state <= SSPI_IDLE;
					end
				end
			endcase
		end
	end

	// clock low except high phases; enable active low
	always_ff @(posedge mclk) begin
		if (rst) begin
			txBitClockOut <= 1'b0;
			txBitClockOe <= 1'b0;
			txFrameSyncOut <= 1'b1;
			txFrameSyncOe <= 1'b0;
			txBusy <= 1'b0;
		end else begin
			txBitClockOut <= masterMode && state == SSPI_HIGH;
			txBitClockOe <= masterMode;
			txFrameSyncOut <= ~(masterMode && txSyncPolarity && state != SSPI_IDLE);
			txFrameSyncOe <= masterMode;
			txBusy <= (masterMode && (state != SSPI_IDLE || armed)) || (!masterMode && slaveSelect);
		end
	end

	// shift engine: launch/capture edge by mode, master or slave clock
	logic rise;
	logic fall;
	logic active;
	always_comb begin
		rise = 1'b0;
		fall = 1'b0;
		active = 1'b0;
		if (masterMode) begin
			// events on the edge where the registered clock pin moves
			rise = state == SSPI_HIGH && !txBitClockOut;
			fall = state != SSPI_HIGH && txBitClockOut;
			active = state != SSPI_IDLE;
		end else begin
			rise = slaveSelect && sclkSync[1] == sclkSync[2] && sclkSync[2] && !sclkPrev;
			fall = slaveSelect && sclkSync[1] == sclkSync[2] && !sclkSync[2] && sclkPrev;
			active = slaveSelect;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			shiftOut <= '0;
			shiftIn <= '0;
			serialDataOut <= 1'b0;
			serialDataOutOe <= 1'b0;
			rxWord <= '0;
			rxValid <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			if ((masterMode && state == SSPI_IDLE && armed && srcTick)
				|| (!masterMode && slaveSelect && !slaveSelectPrev)) begin
				// mode 11b: first bit already on the pin, first fall sends the second
				shiftOut <= fallLaunch ? {txWord[WORD_W-2:0], 1'b0} : txWord;
				shiftIn <= '0;
				// mode 11b first bit ready with enable
				serialDataOut <= txWord[WORD_W-1];
				serialDataOutOe <= 1'b1;
			end
			if (active && (fallLaunch ? fall : rise)) begin
				serialDataOut <= shiftOut[WORD_W-1];
				shiftOut <= {shiftOut[WORD_W-2:0], 1'b0};
			end
			if (active && (fallLaunch ? rise : fall)) begin
				shiftIn <= {shiftIn[WORD_W-2:0], sdiSync[2]};
			end
			// master release one low phase after the last fall
			if (masterMode && (state == SSPI_TAIL || frameEnd)) begin
				serialDataOutOe <= 1'b0;
			end
			if (masterMode && ((state == SSPI_TAIL && phaseDone) || frameEnd)) begin
				rxWord <= shiftIn;
				rxValid <= 1'b1;
			end
			if (!masterMode && !slaveSelect && slaveSelectPrev) begin
				serialDataOutOe <= 1'b0;
				rxWord <= shiftIn;
				rxValid <= 1'b1;
			end
		end
	end
endmodule : sspi_clock_stop

// ==== sspi_clock_stop_assertions.sv ====
// checker: bit clock timing, pin directions and data release of the port
`timescale 1ns/10ps
module sspi_clock_stop_checker #(
	parameter int DIV_W = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic masterMode,
	input wire logic [1:0] clockStopMode,
	input wire logic rateGenSourceSelect,
	input wire logic [DIV_W-1:0] clockDivider,
	input wire logic txBusy,
	input wire logic txClockDirection,
	input wire logic rxClockDirection,
	input wire logic txSyncDirection,
	input wire logic rxSyncDirection,
	input wire logic txBitClockOut,
	input wire logic txFrameSyncOut,
	input wire logic txFrameSyncIn,
	input wire logic serialDataOut,
	input wire logic serialDataOutOe
);
	logic prevClk;
	logic [11:0] runCnt;
	logic [11:0] expHigh;
	logic [11:0] expLow;
	logic evenDiv;
	logic cpuMaster;
	// widths in mclk cycles, cpu/4 source only
	assign evenDiv = !clockDivider[0] && clockDivider != '0;
	assign expLow = evenDiv ? 12'(clockDivider) * 12'h2 : (12'(clockDivider) + 12'h1) * 12'h2;
	assign expHigh = evenDiv ? expLow + 12'h4 : expLow;
	assign cpuMaster = masterMode && rateGenSourceSelect;
	// length of the current clock level, zero while deselected
	always_ff @(posedge mclk) begin
		prevClk <= txBitClockOut;
		runCnt <= txFrameSyncOut ? 12'h0 : (txBitClockOut != prevClk) ? 12'h1 : runCnt + 12'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_dir_pins: assert property (
		!$past(rst) && $stable(masterMode) |-> !rxClockDirection && !rxSyncDirection
		&& txClockDirection == masterMode && txSyncDirection == masterMode)
		else $error("direction bits wrong");
	a_high_width: assert property (
		cpuMaster && $fell(txBitClockOut) |-> runCnt == expHigh) else $error("high phase wrong");
	a_low_width: assert property (
		cpuMaster && clockStopMode == 2'h2 && $rose(txBitClockOut) |-> runCnt == expLow)
		else $error("low phase wrong");
	a_trail_len: assert property (
		cpuMaster && $rose(txFrameSyncOut)
		|-> runCnt == (clockStopMode == 2'h2 ? expHigh + expLow : expLow))
		else $error("enable trail wrong");
	a_data_release: assert property (
		cpuMaster && clockStopMode == 2'h2 && $fell(serialDataOutOe) |-> runCnt == expLow)
		else $error("data release wrong");
	a_launch_edge: assert property (
		masterMode && !txFrameSyncOut && !$past(txFrameSyncOut) && serialDataOutOe
		&& $past(serialDataOutOe) && $changed(serialDataOut)
		|-> (clockStopMode == 2'h2 ? $rose(txBitClockOut) : $fell(txBitClockOut)))
		else $error("data launched on wrong edge");
	a_idle_levels: assert property (
		masterMode && !txBusy && !$past(txBusy) |-> !txBitClockOut && txFrameSyncOut)
		else $error("idle levels wrong");
	a_slave_release: assert property (
		!masterMode && $rose(txFrameSyncIn) |-> ##[1:6] !serialDataOutOe)
		else $error("slave data not released");
endmodule : sspi_clock_stop_checker

// ==== sspi_peer.sv ====
// partner model: SPI slave on the far side of the master pins
`timescale 1ns/10ps
module sspi_peer (
	input wire logic sclk,
	input wire logic selN,
	input wire logic mosi,
	input wire logic [1:0] mode,
	input wire logic [7:0] reply,
	output logic miso,
	output logic [7:0] got
);
	int nCap = 0;
	initial miso = 1'b0;
	initial got = 8'h00;
	always @(negedge selN) begin
		nCap = 0;
		miso = reply[7];
	end
	always @(sclk) begin
		if (!selN && sclk == (mode == 2'h3)) begin
			got = {got[6:0], mosi};
			nCap++;
		end else if (!selN && nCap > 0 && nCap < 8) begin
			miso = reply[7 - nCap];
		end
	end
	// no pull on the line, so a stale bit must not linger
	always @(posedge selN) miso = ~miso;
endmodule : sspi_peer

// ==== testbench.sv ====
// testbench: master and slave transfers of the clock-stop port
`timescale 1ns/10ps
module testbench;
	import sspi_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic masterMode = 1'b1;
	logic [1:0] clockStopMode = STOP_RISE_LAUNCH;
	logic rateGenSourceSelect = SRC_CPU;
	logic [7:0] clockDivider = SLAVE_DIVIDER;
	logic extRateClock = 1'b0;
	logic txStart = 1'b0;
	logic [7:0] txWord = 8'h00;
	logic [7:0] reply = 8'h00;
	logic tbClk = 1'b0;
	logic tbSync = 1'b1;
	logic tbData = 1'b0;
	logic txBusy, rxValid, configError, txBitClockOut, txBitClockOe, txFrameSyncOut;
	logic txFrameSyncOe, serialDataOut, serialDataOutOe, peerMiso, bitClk, syncWire;
	logic txClockDirection, rxClockDirection, txSyncDirection, rxSyncDirection;
	logic [7:0] rxWord, got;
	logic [7:0] sWord = 8'h00;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	// wire level of the two-way pins
	assign bitClk = txBitClockOe ? txBitClockOut : tbClk;
	assign syncWire = txFrameSyncOe ? txFrameSyncOut : tbSync;
	sspi_clock_stop i_dut(.*, .txClockPolarity(1'b0), .txSyncPolarity(1'b1),
		.rxSyncPolarity(1'b1), .txBitClockIn(bitClk), .txFrameSyncIn(syncWire),
		.rxFrameSyncIn(tbSync), .serialDataIn(masterMode ? peerMiso : tbData));
	sspi_peer i_peer(.sclk(bitClk), .selN(syncWire), .mosi(serialDataOut),
		.mode(clockStopMode), .reply(reply), .miso(peerMiso), .got(got));
	initial forever #4 mclk = ~mclk;
	// offset keeps the pin edges off the mclk edges
	initial begin
		#1;
		forever #12 extRateClock = ~extRateClock;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task close_out;
		if (errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	// second start mid-frame must be ignored
	task automatic master_xfer(input logic [1:0] m, input logic s, input logic [7:0] d, w);
		int n;
		clockStopMode = m;
		rateGenSourceSelect = s;
		clockDivider = d;
		txWord = w;
		reply = ~w;
		repeat (3) @(negedge mclk);
		txStart = 1'b1;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
			txStart = (n == 20);
		end while (rxValid !== 1'b1 && n < 3000);
		chk("rxWord", ~w, rxWord);
		chk("peerWord", w, got);
		repeat (3) @(negedge mclk);
		chk("txBusy", 8'h0, txBusy);
		chk("dataOe", 8'h0, serialDataOutOe);
		chk("syncOut", 8'h1, txFrameSyncOut);
	endtask : master_xfer
	initial begin
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		chk("txDir", 8'h1, txClockDirection);
		for (int i = 0; i < 6; i++) begin
			master_xfer(i[0] ? STOP_FALL_LAUNCH : STOP_RISE_LAUNCH, SRC_CPU, 8'(i / 2 + 1), 8'(53 + i * 29));
		end
		master_xfer(STOP_RISE_LAUNCH, 1'b0, 8'h02, 8'hc6);
		masterMode = 1'b0;
		txWord = 8'h5a;
		clockDivider = 8'h02;
		repeat (3) @(negedge mclk);
		chk("cfgErr", 8'h1, configError);
		clockDivider = SLAVE_DIVIDER;
		clockStopMode = STOP_RISE_LAUNCH;
		rateGenSourceSelect = SRC_CPU;
		repeat (3) @(negedge mclk);
		chk("cfgErr", 8'h0, configError);
		chk("txDir", 8'h0, txClockDirection);
		tbSync = 1'b0;
		repeat (8) @(negedge mclk);
		for (int i = 7; i >= 0; i--) begin
			tbClk = 1'b1;
			tbData = i[0] ^ i[1];
			repeat (8) @(negedge mclk);
			sWord = {sWord[6:0], serialDataOut};
			tbClk = 1'b0;
			repeat (8) @(negedge mclk);
		end
		chk("slaveOe", 8'h1, serialDataOutOe);
		tbSync = 1'b1;
		tbData = ~tbData;
		for (int n = 0; n < 20 && rxValid !== 1'b1; n++) @(negedge mclk);
		chk("slaveWord", 8'h66, rxWord);
		chk("slaveOut", 8'h5a, sWord);
		repeat (6) @(negedge mclk);
		chk("slaveOe", 8'h0, serialDataOutOe);
		close_out();
	end
endmodule : testbench
bind sspi_clock_stop sspi_clock_stop_checker #(.DIV_W(DIV_W)) i_chk(.*);
